// File: rtl/ttx_encoder.sv
// Purpose: teletext request timing, sampling and insertion at encoder end
// Assumes: hsync_lead is a one-cycle pulse on clk_sys at the sync edge
// Notes:   insertion point fixed; the request rise edge moves by the timing field, the fall follows the last bit
//
// Overview of operation
// - data appears 10.2 us after sync edge
// - source delivers after its pipeline delay
// - request rise position programmable; fall follows the last bit
// - field zero gives full 360-bit window
// - enable cleared keeps window closed
// - 37 bits take exactly 144 cycles
// - bits 10,19,28,37 three cycles, others four
// - short-bit pattern repeats every 37 bits
// - same timing all lines, per-line select
// - resample through sequencer and phase interpolator
`timescale 1ns/10ps
module ttx_encoder
	import ttx_pkg::*;
(
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst,
	// video timing
	input  wire logic                hsync_lead,
	// control
	input  wire logic                teletext_enable_bit,
	input  wire logic                line_select,
	input  wire logic [TIMING_W-1:0] request_timing_field,
	// link
	ttx_link_if.encoder              link,
	// output samples and insert flag
	output logic [SAMPLE_W-1:0]      composite_output,
	output logic [SAMPLE_W-1:0]      luma_output,
	output logic                     insert_active
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ttx_state_t                 state;
	logic [SYNC_CNT_W-1:0]      since_sync;
	logic [TIMING_W-1:0]        timing;
	logic                       req_q;
	logic                       d_s1;
	logic                       d_s2;
	logic [CYC_CNT_W-1:0]       cyc;
	logic [GRP_CNT_W-1:0]       pos;
	logic [BIT_CNT_W-1:0]       taken;
	logic                       bit_q;
	logic                       bit_prev;
	logic [1:0]                 phase;
	logic                       ins;
	logic [SAMPLE_W-1:0]        next_sample;
	logic [SYNC_CNT_W-1:0]      rise_at;

	// request leads the insertion point by the programmed field plus 3 cycles
	// the lead must cover the source's sync pair, its pipeline and our sync pair,
	// or bits are caught on their edges; a field of 5 to 7 suits a 2-cycle source
	assign rise_at = SYNC_CNT_W'(SYNC_DELAY_CYC) - SYNC_CNT_W'(timing * REQ_STEP_CYC) - 12'd4;

	// ------------------------------------------------------------
	// setup capture, once per line
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			timing <= TIMING_RESET;
		else if (hsync_lead)
			timing <= request_timing_field;

	// data pin from the source: two flip-flops first
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			d_s1 <= 1'b0;
			d_s2 <= 1'b0;
		end
		else
		begin
			d_s1 <= link.teletext_data_in;
			d_s2 <= d_s1;
		end

	// ------------------------------------------------------------
	// line sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			state      <= TTX_IDLE;
			since_sync <= '0;
		end
		else if (hsync_lead)
		begin
			since_sync <= '0;
			// every line uses one schedule; the line select gates it
			state <= (teletext_enable_bit && line_select) ? TTX_WAIT : TTX_IDLE;
		end
		else
		begin
			// saturates so a missing sync pulse cannot wrap into a second window
			if (since_sync != '1)
				since_sync <= since_sync + 12'd1;
			case (state)
				TTX_IDLE: state <= TTX_IDLE;
				TTX_WAIT:
					if (!teletext_enable_bit)
						state <= TTX_IDLE;
					else if (since_sync == rise_at)
						state <= TTX_REQ;
				TTX_REQ:
					// request stays up until the last bit has run its full length
					if (!teletext_enable_bit)
						state <= TTX_DONE;
					else if (taken == BIT_CNT_W'(LINE_BITS) && cyc == 3'd0)
						state <= TTX_DONE;
				TTX_DONE: state <= TTX_DONE;
				default: state <= TTX_IDLE;
			endcase
		end

	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			req_q <= 1'b0;
		else
			req_q <= (state == TTX_REQ) && !hsync_lead;

	assign link.teletext_request_out = req_q;

	// ------------------------------------------------------------
	// bit sampler: starts at the fixed insertion point
	// ------------------------------------------------------------
	// a bit is taken on the first cycle of its period; a short bit leaves
	// only one cycle of slack, so the request lead must be set to match
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			cyc   <= '0;
			pos   <= 6'd1;
			taken <= '0;
			bit_q <= 1'b0;
			ins   <= 1'b0;
		end
		else if (state != TTX_REQ || since_sync < SYNC_CNT_W'(SYNC_DELAY_CYC))
		begin
			cyc   <= '0;
			pos   <= 6'd1;
			taken <= '0;
			ins   <= 1'b0;
		end
		else if (cyc == 3'd0 && taken < BIT_CNT_W'(LINE_BITS))
		begin
			bit_q <= d_s2;
			ins   <= 1'b1;
			cyc   <= ttx_bit_len(pos) - 3'd1;
			pos   <= (pos == 6'(GROUP_BITS)) ? 6'd1 : pos + 6'd1;
			taken <= taken + 9'd1;
		end
		else if (cyc != 3'd0)
			cyc <= cyc - 3'd1;
		else
			ins <= 1'b0;

	// ------------------------------------------------------------
	// interpolation: phase steps soften each transition
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			bit_prev <= 1'b0;
			phase    <= 2'd0;
		end
		else if (cyc == 3'd0 && ins)
		begin
			bit_prev <= bit_q;
			phase    <= 2'd0;
		end
		else if (phase != 2'd3)
			phase <= phase + 2'd1;

	// linear blend from previous bit to current one, bandlimits edges
	// a three-cycle bit ends its ramp one step short of full level
	always_comb
	begin
		next_sample = SAMPLE_LO;
		if (ins)
		begin
			if (bit_prev == bit_q)
				next_sample = bit_q ? SAMPLE_HI : SAMPLE_LO;
			else if (bit_q)
				next_sample = SAMPLE_W'((SAMPLE_HI >> 2) * (phase + 2'd1));
			else
				next_sample = SAMPLE_HI - SAMPLE_W'((SAMPLE_HI >> 2) * (phase + 2'd1));
		end
	end

	// luma carries the same samples; no separate chroma path is needed here
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			composite_output <= SAMPLE_LO;
			luma_output      <= SAMPLE_LO;
			insert_active    <= 1'b0;
		end
		else
		begin
			composite_output <= next_sample;
			luma_output      <= next_sample;
			insert_active    <= ins;
		end
endmodule

// File: rtl/ttx_link_if.sv
// Purpose: teletext request and data link between encoder and source
// Assumes: both ends on clk_sys
// Notes:   plain wires, no clocking block
`timescale 1ns/10ps
interface ttx_link_if;
	logic teletext_request_out;
	logic teletext_data_in;
	modport encoder (output teletext_request_out, input teletext_data_in);
	modport source  (input teletext_request_out, output teletext_data_in);
endinterface

// File: rtl/ttx_pkg.sv
// Purpose: shared constants and types for the teletext insertion link
// Assumes: one system clock, 40 MHz
// Notes:   bit timing is counted in system clock cycles
package ttx_pkg;
	// ------------------------------------------------------------
	// clock and time
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS    = 25000;
	localparam int SYNC_DELAY_NS    = 10200; // 10.2 us, in ns
	localparam int SYNC_DELAY_CYC   = (SYNC_DELAY_NS * 1000) / CLK_PERIOD_PS;
	// ------------------------------------------------------------
	// bit schedule
	// ------------------------------------------------------------
	localparam int LINE_BITS        = 360;
	localparam int GROUP_BITS       = 37;
	localparam int GROUP_CYCLES     = 144;
	localparam int LONG_BIT_CYC     = 4;
	localparam int SHORT_BIT_CYC    = 3;
	localparam int SHORT_SPACING    = 9;  // bits 10,19,28,37 of each group
	localparam int BIT_CNT_W        = 9;
	localparam int CYC_CNT_W        = 3;
	localparam int GRP_CNT_W        = 6;
	localparam int TIMING_W         = 4;
	localparam int SYNC_CNT_W       = 12;
	localparam int SAMPLE_W         = 10;
	// request edge step per timing field unit, in cycles
	localparam int REQ_STEP_CYC     = 1;
	localparam logic [SAMPLE_W-1:0] SAMPLE_HI = 10'h1FF;
	localparam logic [SAMPLE_W-1:0] SAMPLE_LO = 10'h000;
	localparam logic [TIMING_W-1:0] TIMING_RESET = 4'h0;

	typedef enum logic [1:0] {
		TTX_IDLE = 2'b00,
		TTX_WAIT = 2'b01,
		TTX_REQ  = 2'b11,
		TTX_DONE = 2'b10
	} ttx_state_t;

	// cycles that a bit of the group lasts; pos is 1-based within group
	function automatic logic [CYC_CNT_W-1:0] ttx_bit_len(input logic [GRP_CNT_W-1:0] pos);
		logic [GRP_CNT_W-1:0] p;
		p = pos;
		if (p == 6'd10 || p == 6'd19 || p == 6'd28 || p == 6'd37)
			return CYC_CNT_W'(SHORT_BIT_CYC);
		else
			return CYC_CNT_W'(LONG_BIT_CYC);
	endfunction
endpackage

// File: rtl/ttx_source.sv
// Purpose: teletext data source end with a fixed pipeline delay
// Assumes: request sampled through two flip-flops
// Notes:   bits follow the same 37-bit / 144-cycle schedule
`timescale 1ns/10ps
module ttx_source
	import ttx_pkg::*;
#(
	parameter int SOURCE_PIPELINE_DELAY = 2
)(
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// link
	ttx_link_if.source            link,
	// user side
	input  wire logic             user_bit,
	output logic                  user_bit_take
);
	// ------------------------------------------------------------
	// request sync and pipeline delay
	// ------------------------------------------------------------
	logic                         req_s1;
	logic                         req_s2;
	logic [SOURCE_PIPELINE_DELAY-1:0] req_pipe;
	logic                         run;
	logic [CYC_CNT_W-1:0]         cyc;
	logic [GRP_CNT_W-1:0]         pos;
	logic [BIT_CNT_W-1:0]         sent;
	logic                         data_q;

	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
		end
		else
		begin
			req_s1 <= link.teletext_request_out;
			req_s2 <= req_s1;
		end

	// source delay is counted from the synchronised request edge (req_s2)
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			req_pipe <= '0;
		else
			req_pipe <= {req_pipe[SOURCE_PIPELINE_DELAY-2:0], req_s2};

	assign run = req_pipe[SOURCE_PIPELINE_DELAY-1];

	// ------------------------------------------------------------
	// bit schedule
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			cyc           <= '0;
			pos           <= 6'd1;
			sent          <= '0;
			data_q        <= 1'b0;
			user_bit_take <= 1'b0;
		end
		else if (!run)
		begin
			cyc           <= '0;
			pos           <= 6'd1;
			sent          <= '0;
			data_q        <= 1'b0;
			user_bit_take <= 1'b0;
		end
		else
		begin
			user_bit_take <= 1'b0;
			if (cyc == 3'd0 && sent < BIT_CNT_W'(LINE_BITS))
			begin
				data_q        <= user_bit;
				user_bit_take <= 1'b1;
				cyc           <= ttx_bit_len(pos) - 3'd1;
				sent          <= sent + 9'd1;
				pos           <= (pos == 6'(GROUP_BITS)) ? 6'd1 : pos + 6'd1;
			end
			else if (cyc != 3'd0)
				cyc <= cyc - 3'd1;
		end

	assign link.teletext_data_in = data_q;
endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for encoder and source joined by the link
// Assumes: 40 MHz clock, one hsync pulse per line of 1901 cycles
// Notes:   interpolated samples are checked for range, not exact shape
`timescale 1ns/10ps
module tb
	import ttx_pkg::*;
;
	localparam int LINE_CYC = 1900;
	localparam int CEIL     = 25000;
	logic                clk_sys;
	logic                rst;
	logic                hsync_lead;
	logic                teletext_enable_bit;
	logic                line_select;
	logic [TIMING_W-1:0] request_timing_field;
	logic                user_bit;
	logic                user_bit_take;
	logic [SAMPLE_W-1:0] composite_output;
	logic [SAMPLE_W-1:0] luma_output;
	logic                insert_active;
	logic [31:0]         seed;
	int                  errors;
	int                  num_checks;
	int                  cycles;
	int                  rise_at;
	int                  act_at;
	int                  act_len;
	int                  r0;
	int                  a0;
	logic [3:0]          t;
	logic [LINE_BITS-1:0] sent_bits;
	logic [LINE_BITS-1:0] got_bits;
	int                  n_sent;
	int                  last_taken;
	ttx_link_if ttx_link_if_i();
	ttx_encoder ttx_encoder_i(.clk_sys(clk_sys), .rst(rst), .hsync_lead(hsync_lead),
		.teletext_enable_bit(teletext_enable_bit), .line_select(line_select),
		.request_timing_field(request_timing_field), .link(ttx_link_if_i),
		.composite_output(composite_output), .luma_output(luma_output),
		.insert_active(insert_active));
	ttx_source #(.SOURCE_PIPELINE_DELAY(2)) ttx_source_i(.clk_sys(clk_sys), .rst(rst),
		.link(ttx_link_if_i), .user_bit(user_bit), .user_bit_take(user_bit_take));
	ttx_link_properties ttx_link_properties_i(.clk_sys(clk_sys), .rst(rst),
		.teletext_request_out(ttx_link_if_i.teletext_request_out),
		.teletext_data_in(ttx_link_if_i.teletext_data_in));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function logic [31:0] nxt();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// cycles needed by the first n bits: short bits sit at 10,19,28,37
	function int sched_len(input int n);
		int len;
		int p;
		len = 0;
		for (int i = 1; i <= n; i++)
		begin
			p = (i - 1) % 37 + 1;
			len += (p % 9 == 1 && p != 1) ? 3 : 4;
		end
		return len;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict();
		if (errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one video line; drop is the cycle at which enable falls, -1 for never
	task run_line(input logic en, input logic sel, input logic [3:0] tf, input int drop);
		rise_at = -1;
		act_at = -1;
		act_len = 0;
		@(posedge clk_sys);
		teletext_enable_bit <= en;
		line_select <= sel;
		request_timing_field <= tf;
		hsync_lead <= 1'b1;
		for (int c = 0; c < LINE_CYC; c++)
		begin
			@(posedge clk_sys);
			hsync_lead <= 1'b0;
			if (c == 100)
				request_timing_field <= 4'(nxt());
			if (c == drop)
				teletext_enable_bit <= 1'b0;
			@(negedge clk_sys);
			if (ttx_link_if_i.teletext_request_out === 1'b1 && rise_at < 0)
				rise_at = c;
			if (insert_active === 1'b1)
			begin
				if (act_at < 0)
					act_at = c;
				act_len++;
			end
		end
	endtask
	// ------------------------------------------------------------
	// clock, source feed, sample watch, timeout
	// ------------------------------------------------------------
	initial clk_sys = 1'b0;
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (hsync_lead === 1'b1)
			n_sent = 0;
		else if (user_bit_take === 1'b1)
		begin
			if (n_sent < LINE_BITS)
				sent_bits[n_sent] = user_bit;
			n_sent++;
			user_bit <= 1'(nxt());
		end
	// the bit the encoder latched, by its position in the line
	always @(negedge clk_sys)
		if (ttx_encoder_i.taken != last_taken)
		begin
			if (ttx_encoder_i.taken != '0)
				got_bits[ttx_encoder_i.taken - 1] = ttx_encoder_i.bit_q;
			last_taken = ttx_encoder_i.taken;
		end
	always @(negedge clk_sys)
		if (!rst)
		begin
			if (insert_active === 1'b1)
				check({composite_output > SAMPLE_HI, composite_output}, {1'b0, luma_output});
			else
				check(composite_output, SAMPLE_LO);
		end
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == CEIL)
		begin
			errors++;
			give_verdict();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		seed = 32'hB2D2;
		errors = 0;
		num_checks = 0;
		cycles = 0;
		n_sent = 0;
		last_taken = 0;
		rst = 1'b1;
		hsync_lead = 1'b0;
		teletext_enable_bit = 1'b0;
		line_select = 1'b0;
		request_timing_field = 4'h0;
		user_bit = 1'b0;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		run_line(1'b1, 1'b1, 4'h0, -1);
		r0 = rise_at;
		a0 = act_at;
		check(a0 >= SYNC_DELAY_CYC && a0 <= SYNC_DELAY_CYC + 3, 1);
		check(act_len, sched_len(LINE_BITS));
		for (int k = 0; k < 4; k++)
		begin
			t = (k == 0) ? 4'hF : (k == 1) ? 4'h0 : 4'(nxt());
			run_line(1'b1, 1'b1, t, -1);
			check(rise_at + t, r0);
			check(act_at, a0);
			check(act_len, sched_len(LINE_BITS));
		end
		run_line(1'b0, 1'b1, 4'h5, -1);
		check(rise_at, -1);
		check(act_len, 0);
		run_line(1'b1, 1'b0, 4'h3, -1);
		check(rise_at, -1);
		check(act_len, 0);
		run_line(1'b1, 1'b1, 4'h0, 800);
		check(act_len > 0 && act_len <= 800 - a0 + 4, 1);
		run_line(1'b1, 1'b1, 4'h7, -1);
		check(act_len, sched_len(LINE_BITS));
		// a field of 6 centres the sampling on a source with 2 cycles of delay
		run_line(1'b1, 1'b1, 4'h6, -1);
		check(n_sent, LINE_BITS);
		for (int i = 0; i < LINE_BITS; i++)
			check(got_bits[i], sent_bits[i]);
		give_verdict();
	end
endmodule

// File: tb/ttx_link_properties.sv
// Purpose: timing checks on the teletext link wires
// Assumes: one clock, rst async active high
// Notes:   sees only the link, so bit values are judged by the bench
`timescale 1ns/10ps
module ttx_link_properties
	import ttx_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// link
	input wire logic teletext_request_out,
	input wire logic teletext_data_in
);
	logic [11:0] high_cnt;
	logic [11:0] gap_cnt;
	// ------------------------------------------------------------
	// helper counters
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			high_cnt <= 12'h000;
		else
			high_cnt <= teletext_request_out ? high_cnt + 12'h001 : 12'h000;
	// saturates so the first rise after reset always passes
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			gap_cnt <= 12'hFFF;
		else if ($rose(teletext_request_out))
			gap_cnt <= 12'h000;
		else if (gap_cnt != 12'hFFF)
			gap_cnt <= gap_cnt + 12'h001;
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_bit_hold;
		$stable(teletext_data_in)[*2];
	endsequence
	sequence s_req_open;
		teletext_request_out[*8];
	endsequence
	a_req_reset_quiet: assert property ($fell(rst) |-> !teletext_request_out[*8])
		else $error("request raised right after reset");
	a_req_min_width: assert property ($rose(teletext_request_out) |-> s_req_open)
		else $error("request window too short");
	a_req_max_width: assert property (high_cnt <= 12'd1440)
		else $error("request window too long");
	// the run length is counted in high_cnt; a delay range this long would unroll
	a_req_ends_bounded: assert property (teletext_request_out |-> high_cnt < 12'd1450)
		else $error("request never closed");
	a_req_rise_spacing: assert property ($rose(teletext_request_out) |-> gap_cnt >= 12'd1700)
		else $error("second request within one line");
	a_req_fall_gap: assert property ($fell(teletext_request_out) |-> !teletext_request_out[*8])
		else $error("request reopened at once");
	a_bit_min_len: assert property ((teletext_request_out && $changed(teletext_data_in)) |-> ##1 s_bit_hold)
		else $error("teletext bit shorter than three cycles");
	a_lead_data_still: assert property ($rose(teletext_request_out) |-> s_bit_hold)
		else $error("data moved before source delay");
endmodule
